// ===== rtl/bus_front_end.sv
// bus front end: ahb-lite registers, generator polling and output fifo
`timescale 1ns/1ps
module bus_front_end (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    rng_link_if.host link
);
    import rng_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [1:0] {H_IDLE, H_POLL, H_FETCH} host_state_e;

    typedef struct packed {
        host_state_e state;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [COUNT_W-1:0] count;
        logic [FIFO_DEPTH-1:0][WORD_W-1:0] fifo;
        logic [FIFO_AW-1:0] wp;
        logic [FIFO_AW-1:0] rp;
        logic [4:0] level;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic irq;
        logic [31:0] hrdata;
        logic wr_pend;
        logic [7:0] wr_addr;
    } host_s;

    host_s s;
    host_s next_s;
    logic push;
    logic pop;
    logic [1:0] set_ev;
    logic [1:0] clr_ev;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_s = s;
        push = 1'b0;
        pop = 1'b0;
        set_ev = 2'b00;
        clr_ev = 2'b00;

        // generator sequencing
        unique case (s.state)
            H_IDLE: begin
                // stall polling while the fifo is full
                if (s.count != '0 && s.level != LEVEL_FULL) begin
                    next_s.rd = 1'b1;
                    next_s.addr = STATUS_OFS;
                    next_s.state = H_POLL;
                end
            end
            H_POLL: begin
                if (link.ack) begin
                    if (link.rdata[READY_BIT]) begin
                        next_s.addr = RANDOM_OFS;
                        next_s.state = H_FETCH;
                    end else begin
                        next_s.rd = 1'b0;
                        next_s.state = H_IDLE;
                    end
                end
            end
            H_FETCH: begin
                if (link.ack) begin
                    next_s.rd = 1'b0;
                    next_s.state = H_IDLE;
                    push = 1'b1;
                    next_s.fifo[s.wp] = link.rdata;
                    next_s.wp = s.wp + 4'h1;
                    next_s.count = s.count - 16'h0001;
                    if (s.count == 16'h0001) begin
                        set_ev[IRQ_DONE_BIT] = 1'b1;
                    end
                end
            end
        endcase

        // ahb address phase; reads answered in the next cycle
        next_s.wr_pend = 1'b0;
        if (hsel && htrans[1] && hready) begin
            if (hwrite) begin
                next_s.wr_pend = 1'b1;
                next_s.wr_addr = haddr[7:0];
            end else begin
                case (haddr[7:0])
                    REG_COUNT: next_s.hrdata = {16'h0000, s.count};
                    REG_DATA: begin
                        next_s.hrdata = s.fifo[s.rp];
                        if (s.level != 5'h00) begin
                            pop = 1'b1;
                            next_s.rp = s.rp + 4'h1;
                        end else begin
                            set_ev[IRQ_UNDER_BIT] = 1'b1;
                        end
                    end
                    REG_IRQ_STATUS: begin
                        next_s.hrdata = {30'h0, s.irq_stat};
                        clr_ev = s.irq_stat;
                    end
                    REG_IRQ_MASK: next_s.hrdata = {30'h0, s.irq_mask};
                    REG_LEVEL: next_s.hrdata = {27'h0, s.level};
                    default: next_s.hrdata = 32'h0000_0000;
                endcase
            end
        end

        // ahb data phase of a write
        if (s.wr_pend) begin
            unique case (s.wr_addr)
                REG_COUNT: next_s.count = hwdata[COUNT_W-1:0];
                REG_IRQ_MASK: next_s.irq_mask = hwdata[1:0];
                default: ;
            endcase
        end

        if (push && !pop) begin
            next_s.level = s.level + 5'h01;
        end else if (pop && !push) begin
            next_s.level = s.level - 5'h01;
        end

        // set wins over read clear
        next_s.irq_stat = (s.irq_stat & ~clr_ev) | set_ev;
        next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s.hrdata;
    assign irq = s.irq;
    assign link.rd = s.rd;
    assign link.addr = s.addr;
    assign link.wr = 1'b0;
    assign link.wdata = '0;

endmodule

// ===== rtl/rng_pkg.sv
// shared constants for the random word generator and its bus front end
package rng_pkg;

    // ****************************************
    // generator register port
    // ****************************************
    localparam logic [11:0] STATUS_OFS = 12'h600;
    localparam logic [11:0] RANDOM_OFS = 12'h602;
    localparam int READY_BIT = 18;
    localparam int ON_BIT = 31;
    localparam int ADDR_W = 12;
    localparam int WORD_W = 32;

    // ****************************************
    // generator internals
    // ****************************************
    localparam int LFSR_W = 32;
    localparam int CA_W = 43;
    localparam logic [31:0] LFSR_TAPS = 32'h8020_0003;
    localparam logic [31:0] LFSR_SEED = 32'h0000_0001;
    localparam logic [42:0] CA_SEED = 43'h1;
    localparam logic [42:0] CA_R150 = 43'h800;
    localparam logic [7:0] OSC_A_PERIOD = 8'h06;
    localparam logic [7:0] OSC_B_PERIOD = 8'h0A;
    localparam logic [7:0] FRESH_STEPS = 8'h04;

    // ****************************************
    // front end registers (byte offsets on ahb)
    // ****************************************
    localparam logic [7:0] REG_COUNT = 8'h00;
    localparam logic [7:0] REG_DATA = 8'h04;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [7:0] REG_LEVEL = 8'h10;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_UNDER_BIT = 1;
    localparam int COUNT_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
    localparam logic [4:0] LEVEL_FULL = 5'h10;

endpackage

// ===== rtl/rng_link_if.sv
// register link between the bus front end and the random word generator
`timescale 1ns/1ps
interface rng_link_if;
    import rng_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic rd;
    logic wr;
    logic [WORD_W-1:0] wdata;
    logic [WORD_W-1:0] rdata;
    logic ack;

    modport device (
        input addr,
        input rd,
        input wr,
        input wdata,
        output rdata,
        output ack
    );

    modport host (
        output addr,
        output rd,
        output wr,
        output wdata,
        input rdata,
        input ack
    );
endinterface

// ===== rtl/random_word_generator.sv
// random word generator: oscillator-stepped lfsr and cellular automaton behind a register port
//
// Operation
// - one 32-bit word per random read
// - lfsr and automaton run side by side
// - two free oscillators step the registers
// - read halts oscillators, xor forms word
// - status bit 18 flags word ready
// - early random read stalls until ready
// - status bit 31 shows generator running
// - front end reads only after ready
// - front end pushes words until count zero
// - next read may follow ready directly
// - front end may interrupt when done
// - cpu writes word count first
`timescale 1ns/1ps
module random_word_generator (
    input wire logic hclk,
    input wire logic hresetn,
    rng_link_if.device link,
    output logic gen_active
);
    import rng_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [LFSR_W-1:0] lfsr;
        logic [CA_W-1:0] ca;
        logic [7:0] osc_a;
        logic [7:0] osc_b;
        // one less than the a ticks still owed before a new word may be shown
        logic [7:0] fresh;
        logic ready;
        logic on;
        logic ack;
        logic [WORD_W-1:0] rdata;
    } dev_s;

    localparam dev_s RESET_S = '{
        lfsr: LFSR_SEED,
        ca: CA_SEED,
        osc_a: OSC_A_PERIOD,
        osc_b: OSC_B_PERIOD,
        fresh: FRESH_STEPS,
        ready: 1'b0,
        on: 1'b0,
        ack: 1'b0,
        rdata: '0
    };

    dev_s s;
    dev_s next_s;

    // ****************************************
    // step and mixing functions
    // ****************************************
    // galois form: the bit shifted out folds back in through the taps
    function automatic logic [LFSR_W-1:0] lfsr_step(input logic [LFSR_W-1:0] v);
        logic [LFSR_W-1:0] shifted;
        shifted = v >> 1;
        if (v[0]) begin
            lfsr_step = shifted ^ LFSR_TAPS;
        end else begin
            lfsr_step = shifted;
        end
    endfunction

    // rule 90 everywhere, rule 150 where the mask is set, null edges
    function automatic logic [CA_W-1:0] ca_step(input logic [CA_W-1:0] v);
        logic [CA_W-1:0] left;
        logic [CA_W-1:0] right;
        left = {1'b0, v[CA_W-1:1]};
        right = {v[CA_W-2:0], 1'b0};
        ca_step = left ^ right ^ (v & CA_R150);
    endfunction

    // both automaton ends are folded in, so every cell reaches the word
    function automatic logic [WORD_W-1:0] mix(input logic [LFSR_W-1:0] l, input logic [CA_W-1:0] c);
        logic [WORD_W-1:0] upper;
        logic [WORD_W-1:0] lower;
        upper = c[CA_W-1:CA_W-WORD_W];
        lower = c[WORD_W-1:0];
        mix = l ^ upper ^ lower;
    endfunction

    // a tick is the cycle the count sits at zero
    function automatic logic osc_tick(input logic [7:0] cnt);
        osc_tick = cnt == 8'h00;
    endfunction

    // reload on zero: one tick every reload plus one cycles
    function automatic logic [7:0] osc_next(input logic [7:0] cnt, input logic [7:0] reload);
        if (osc_tick(cnt)) begin
            osc_next = reload;
        end else begin
            osc_next = cnt - 8'h01;
        end
    endfunction

    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        addr_is = a == ofs;
    endfunction

    function automatic logic [WORD_W-1:0] status_word(input logic on, input logic ready);
        logic [WORD_W-1:0] w;
        w = '0;
        w[ON_BIT] = on;
        w[READY_BIT] = ready;
        status_word = w;
    endfunction

    // ****************************************
    // next state
    // ****************************************
    logic req;
    logic take;
    logic is_rand;
    logic is_stat;
    logic rd_rand;
    logic halt;
    logic tick_a;
    logic tick_b;
    logic fresh_due;

    always_comb begin
        next_s = s;
        next_s.ack = 1'b0;
        // writes are acked too, so a stray write cannot hang the host
        req = link.rd || link.wr;
        // one request per ack; a held request is not taken twice
        take = req && !s.ack;
        is_rand = addr_is(link.addr, RANDOM_OFS);
        is_stat = addr_is(link.addr, STATUS_OFS);
        rd_rand = take && link.rd && is_rand;
        halt = rd_rand && s.ready;
        tick_a = osc_tick(s.osc_a);
        tick_b = osc_tick(s.osc_b);
        fresh_due = !s.ready && tick_a;

        // limitation: ticks live in the hclk domain, so the rates are fixed
        if (!halt) begin
            next_s.osc_a = osc_next(s.osc_a, OSC_A_PERIOD);
            next_s.osc_b = osc_next(s.osc_b, OSC_B_PERIOD);
            if (tick_a) begin
                next_s.lfsr = lfsr_step(s.lfsr);
            end
            if (tick_b) begin
                next_s.ca = ca_step(s.ca);
            end
            if (fresh_due) begin
                if (s.fresh == 8'h00) begin
                    next_s.ready = 1'b1;
                    next_s.on = 1'b1;
                end else begin
                    next_s.fresh = s.fresh - 8'h01;
                end
            end
        end

        // an early random read is not taken; rd stays up and is seen again
        if (rd_rand) begin
            // no ack while not ready, host holds
            if (s.ready) begin
                next_s.rdata = mix(s.lfsr, s.ca);
                next_s.ack = 1'b1;
                next_s.ready = 1'b0;
                next_s.fresh = FRESH_STEPS;
            end
        end else if (take) begin
            next_s.ack = 1'b1;
            // unmapped reads answer zero rather than stall
            next_s.rdata = (link.rd && is_stat) ? status_word(s.on, s.ready) : '0;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // seeds are nonzero: an all-zero lfsr would never leave zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= RESET_S;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign link.ack = s.ack;
    assign link.rdata = s.rdata;
    // never falls again: nothing here powers the generator down
    assign gen_active = s.on;

endmodule

// ===== verif/rng_link_chk.sv
// assertions on the register link between the bus front end and the generator
`timescale 1ns/1ps
module rng_link_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [rng_pkg::ADDR_W-1:0] addr,
    input wire logic rd,
    input wire logic wr,
    input wire logic [rng_pkg::WORD_W-1:0] wdata,
    input wire logic [rng_pkg::WORD_W-1:0] rdata,
    input wire logic ack
);
    import rng_pkg::*;
    // ****************************************
    // helper state
    // ****************************************
    localparam logic [31:0] KNOWN = (32'h1 << READY_BIT) | (32'h1 << ON_BIT);
    logic [31:0] last_word;
    logic have_word;
    logic ready_known;
    logic stat_ack;
    logic rand_ack;
    assign stat_ack = ack && addr == STATUS_OFS;
    assign rand_ack = ack && addr == RANDOM_OFS;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_word <= '0;
            have_word <= 1'b0;
            ready_known <= 1'b0;
        end else if (rand_ack) begin
            last_word <= rdata;
            have_word <= 1'b1;
            ready_known <= 1'b0;
        end else if (stat_ack && rdata[READY_BIT]) begin
            ready_known <= 1'b1;
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence ready_seen_s;
        stat_ack && rdata[READY_BIT];
    endsequence
    sequence rand_wait_s;
        rd && !ack && addr == RANDOM_OFS;
    endsequence
    ack_one_cycle_a: assert property (ack |=> !ack)
        else $error("link ack longer than one cycle");
    ack_has_request_a: assert property (ack |-> $past(rd || wr))
        else $error("link ack without request");
    data_on_ack_a: assert property ($changed(rdata) |-> ack)
        else $error("link read data changed outside an answer");
    ready_prompt_a: assert property (ready_seen_s ##1 rand_wait_s |=> ack)
        else $error("random read stalled although ready shown");
    reserved_zero_a: assert property (stat_ack |-> (rdata & ~KNOWN) == '0)
        else $error("status reserved bits not zero");
    on_when_ready_a: assert property (ready_seen_s |-> rdata[ON_BIT])
        else $error("ready shown while running bit low");
    fresh_word_a: assert property (rand_ack && have_word |-> rdata != last_word)
        else $error("random word repeated");
    ready_cleared_a: assert property (rand_ack |=> (!stat_ack || !rdata[READY_BIT]) [*8])
        else $error("ready flag not cleared after random read");
    read_after_ready_a: assert property (rand_ack |-> ready_known)
        else $error("random read without ready seen");
endmodule

// ===== verif/tb.sv
// testbench: ahb-lite master on the front end, generator across the link
`timescale 1ns/1ps
module tb;
    import rng_pkg::*;
    typedef struct {logic [31:0] v; logic [31:0] m;} exp_s;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic irq;
    logic gen_active;
    logic dphase;
    logic [31:0] rv;
    logic [31:0] n;
    logic [7:0] regs [5] = '{REG_COUNT, REG_IRQ_STATUS, REG_IRQ_MASK, REG_LEVEL, 8'h14};
    exp_s cur;
    exp_s exp_q [$];
    int n_fail;
    int n_checks;
    rng_link_if link ();
    bus_front_end bus_front_end_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .link(link));
    random_word_generator random_word_generator_inst (.hclk(hclk), .hresetn(hresetn), .link(link),
        .gen_active(gen_active));
    rng_link_chk rng_link_chk_inst (.hclk(hclk), .hresetn(hresetn), .addr(link.addr), .rd(link.rd),
        .wr(link.wr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // ****************************************
    // bus tasks and comparison
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // expectation noted at the address phase, compared by the watcher at the data edge
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, input logic [31:0] m,
        input logic [31:0] e);
        if (!w) begin
            exp_q.push_back('{v: e, m: m});
        end
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask
    task automatic wait_level(input logic [31:0] want, input logic eq);
        int k;
        k = 0;
        do begin
            xfer(REG_LEVEL, 1'b0, 32'h0, 32'h0, 32'h0);
            k++;
        end while (((rv === want) != eq) && k < 3000);
        if ((rv === want) != eq) begin
            n_fail++;
            $display("MISMATCH t=%0t fifo level never reached", $time);
        end
    endtask
    always @(posedge hclk) begin
        if (dphase && hreadyout && exp_q.size() > 0) begin
            cur = exp_q.pop_front();
            check(hrdata & cur.m, cur.v & cur.m);
        end
        if (hreadyout) begin
            dphase <= hsel && htrans[1] && !hwrite;
        end
    end
    // ****************************************
    // tests
    // ****************************************
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        dphase = 1'b0;
        n_fail = 0;
        n_checks = 0;
        void'($urandom(30));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (regs[i]) xfer(regs[i], 1'b0, 32'h0, 32'hFFFF_FFFF, 32'h0);
        check({31'h0, irq}, 32'h0);
        check({31'h0, gen_active}, 32'h0);
        $display("test reset_values done");
        n = 32'h1 + $urandom % 4;
        xfer(REG_IRQ_MASK, 1'b1, 32'h3, 32'h0, 32'h0);
        xfer(REG_COUNT, 1'b1, n, 32'h0, 32'h0);
        wait_level(n, 1'b1);
        check({31'h0, gen_active}, 32'h1);
        xfer(REG_COUNT, 1'b0, 32'h0, 32'hFFFF_FFFF, 32'h0);
        check({31'h0, irq}, 32'h1);
        xfer(REG_IRQ_STATUS, 1'b0, 32'h0, 32'hFFFF_FFFF, 32'h1);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        repeat (n) xfer(REG_DATA, 1'b0, 32'h0, 32'h0, 32'h0);
        xfer(REG_LEVEL, 1'b0, 32'h0, 32'hFFFF_FFFF, 32'h0);
        // empty pop flags underflow
        xfer(REG_DATA, 1'b0, 32'h0, 32'h0, 32'h0);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h1);
        xfer(REG_IRQ_STATUS, 1'b0, 32'h0, 32'hFFFF_FFFF, 32'h2);
        $display("test short_request done");
        // more words than the fifo holds: polling must pause at full
        xfer(REG_COUNT, 1'b1, FIFO_DEPTH + 4, 32'h0, 32'h0);
        wait_level({27'h0, LEVEL_FULL}, 1'b1);
        xfer(REG_COUNT, 1'b0, 32'h0, 32'hFFFF_FFFF, 32'h4);
        repeat (FIFO_DEPTH + 4) begin
            wait_level(32'h0, 1'b0);
            xfer(REG_DATA, 1'b0, 32'h0, 32'h0, 32'h0);
        end
        xfer(REG_LEVEL, 1'b0, 32'h0, 32'hFFFF_FFFF, 32'h0);
        xfer(REG_IRQ_STATUS, 1'b0, 32'h0, 32'hFFFF_FFFF, 32'h1);
        $display("test fill_drain done");
        end_of_test();
    end
    initial begin
        #300000;
        n_fail++;
        end_of_test();
    end
endmodule
